// ==== tb/rom_socket_virtual_serial_port_tb.sv ====
// Self-checking bench for the ROM socket virtual serial port
`timescale 1ns/1ps
`default_nettype none
module rom_socket_virtual_serial_port_tb
   import rsv_pkg::*;
;
   // Clock, reset and straps
   logic clk = 1'b0;
   logic srst = 1'b1;
   rsv_variant_t variant = rsv_variant_two;
   logic [1:0] lane_shift = 2'h0;
   logic [2:0] burst_shift = 3'h0;
   logic slave_fitted = 1'b1;
   logic master_high_lane = 1'b0;
   logic shared_write = 1'b0;
   logic rx_int_en = 1'b1;
   logic tx_int_en = 1'b0;
   // Host side
   logic host_char_valid = 1'b0;
   logic [7:0] host_char = 8'h00;
   logic host_int_req = 1'b0;
   logic tx_bit_valid;
   logic tx_bit;
   // Target user side
   logic req_rd = 1'b0;
   logic req_wr = 1'b0;
   logic [15:0] req_addr = 16'h0000;
   logic [15:0] req_wdata = 16'h0000;
   logic [1:0] req_lanes = 2'h0;
   logic busy;
   logic rd_valid;
   logic [15:0] rd_data;
   logic irq;
   // Bookkeeping and tables: {variant, lane_shift, burst_shift}; {slave, shared}
   int num_errors = 0;
   int n_tests = 0;
   int tx_cnt = 0;
   int c0;
   int sh;
   logic [7:0] obs = 8'h00;
   logic [7:0] pat = 8'hC6;
   logic [15:0] q;
   logic [15:0] hi;
   logic [5:0] cfg [5] = '{6'h28, 6'h31, 6'h3A, 6'h25, 6'h05};
   logic [1:0] wl [5] = '{2'h3, 2'h1, 2'h2, 2'h2, 2'h1};
   logic [15:0] wd [5] = '{16'h1234, 16'hABCD, 16'hEF99, 16'h0011, 16'h5566};
   logic [15:0] ex [5] = '{16'h1234, 16'h12CD, 16'hEFCD, 16'hEFCD, 16'h5566};
   logic [1:0] ss [5] = '{2'h2, 2'h2, 2'h2, 2'h0, 2'h3};
   rsv_if sock ();
   ////////////////////////////////////////////////////////////////////////
   // Mask and base are fixed: a 2K emulation window at the top of 64K
   rsv_device rsv_device_inst (.clk(clk), .srst(srst), .sock(sock.device), .variant(variant),
      .lane_shift(lane_shift), .burst_shift(burst_shift), .master_high_lane(master_high_lane), .slave_fitted(slave_fitted),
      .shared_write(shared_write), .reg_base(16'hF800), .emu_mask(16'h07FF), .addr_mask(16'h07FF),
      .rx_int_en(rx_int_en), .tx_int_en(tx_int_en), .host_char_valid(host_char_valid), .host_char(host_char),
      .host_int_req(host_int_req), .tx_bit_valid(tx_bit_valid), .tx_bit(tx_bit));
   rsv_target rsv_target_inst (.clk(clk), .srst(srst), .sock(sock.target), .req_rd(req_rd), .req_wr(req_wr),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes), .busy(busy), .rd_valid(rd_valid),
      .rd_data(rd_data), .irq(irq));
   rsv_checker rsv_checker_inst (.clk(clk), .srst(srst), .rd_n(sock.rd_n), .mwr_n(sock.mwr_n),
      .swr_n(sock.swr_n), .addr(sock.addr), .wdata(sock.wdata), .int_n_o(sock.int_n_o),
      .int_n_oe(sock.int_n_oe), .int_p_o(sock.int_p_o), .int_p_oe(sock.int_p_oe));
   ////////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   always #12.5 clk = ~clk;
   // Collect host-bound bits; the oldest of the last eight lands in bit 0
   always @(posedge clk) begin
      if (tx_bit_valid === 1'b1) begin
         tx_cnt <= tx_cnt + 1;
         obs <= {tx_bit, obs[7:1]};
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One socket access; entered and left just after a rising edge
   task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [1:0] ln,
      output logic [15:0] r);
      int n;
      n = 0;
      req_rd <= !wr;
      req_wr <= wr;
      req_addr <= a;
      req_wdata <= d;
      req_lanes <= ln;
      @(posedge clk);
      req_rd <= 1'b0;
      req_wr <= 1'b0;
      @(posedge clk);
      // Bounded wait so a stuck engine cannot hang the run
      @(negedge clk);
      while (busy !== 1'b0 && n < 30) begin
         @(negedge clk);
         n++;
      end
      chk({15'h0, busy}, 16'h0000);
      if (!wr) chk({15'h0, rd_valid}, 16'h0001);
      r = rd_data;
      @(posedge clk);
   endtask
   task automatic send_char(input logic [7:0] c);
      host_char <= c;
      host_char_valid <= 1'b1;
      @(posedge clk);
      host_char_valid <= 1'b0;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({14'h0, sock.int_n_line, sock.int_p_line}, 16'h0002);
      // Character before init must stay silent
      send_char(8'h3C);
      repeat (10) @(posedge clk);
      chk({15'h0, sock.int_p_line}, 16'h0000);
      acc(1'b0, 16'hF802, 16'h0000, 2'h3, q);
      chk({8'h00, q[7:0]}, 16'h003C);
      acc(1'b0, 16'hF803, 16'h0000, 2'h3, q);
      chk({14'h0, q[1:0]}, 16'h0002);
      acc(1'b0, 16'hF803, 16'h0000, 2'h3, q);
      chk({13'h0, q[2:0]}, 16'h0006);
      $display("test init done");
      // Character after init interrupts until read
      send_char(8'h5A);
      repeat (8) @(posedge clk);
      chk({13'h0, sock.int_n_line, sock.int_p_line, irq}, 16'h0003);
      acc(1'b0, 16'hF802, 16'h0000, 2'h3, q);
      chk({8'h00, q[7:0]}, 16'h005A);
      chk({14'h0, sock.int_n_line, sock.int_p_line}, 16'h0002);
      // Host handshake request
      host_int_req <= 1'b1;
      repeat (8) @(posedge clk);
      chk({14'h0, sock.int_n_line, sock.int_p_line}, 16'h0001);
      host_int_req <= 1'b0;
      acc(1'b0, 16'hF802, 16'h0000, 2'h3, q);
      chk({14'h0, sock.int_n_line, sock.int_p_line}, 16'h0002);
      // Receive interrupts switched off: the character waits silently
      rx_int_en <= 1'b0;
      send_char(8'h77);
      repeat (8) @(posedge clk);
      chk({14'h0, sock.int_n_line, sock.int_p_line}, 16'h0002);
      acc(1'b0, 16'hF802, 16'h0000, 2'h3, q);
      chk({8'h00, q[7:0]}, 16'h0077);
      rx_int_en <= 1'b1;
      $display("test receive done");
      // A character sent by reads alone, then the idle interrupt
      tx_int_en <= 1'b1;
      c0 = tx_cnt;
      for (int i = 0; i < 8; i++) acc(1'b0, 16'hF800 + {15'h0, pat[i]}, 16'h0000, 2'h3, q);
      repeat (4) @(posedge clk);
      chk(16'(tx_cnt - c0), 16'h0008);
      chk({8'h00, obs}, 16'h00C6);
      chk({14'h0, sock.int_n_line, sock.int_p_line}, 16'h0001);
      acc(1'b0, 16'hF802, 16'h0000, 2'h3, q);
      chk({14'h0, sock.int_n_line, sock.int_p_line}, 16'h0002);
      tx_int_en <= 1'b0;
      $display("test transmit done");
      // Decode over widths and bursts; variant two ignores lines above 2K
      c0 = tx_cnt;
      for (int k = 0; k < 5; k++) begin
         variant <= rsv_variant_t'(cfg[k][5]);
         lane_shift <= cfg[k][4:3];
         burst_shift <= cfg[k][2:0];
         @(posedge clk);
         sh = cfg[k][4:3] + ((!cfg[k][5] && cfg[k][2:0] > 3'h4) ? 4 : cfg[k][2:0]);
         // Variant one gets the unused upper lines held high; its 07FF mask drops them as well
         hi = cfg[k][5] ? 16'h0000 : 16'hF800;
         acc(1'b0, hi + (16'h1 << sh) - 16'h1, 16'h0000, 2'h3, q);
         acc(1'b0, hi + (16'h2 << sh) - 16'h1, 16'h0000, 2'h3, q);
         acc(1'b0, hi + (16'h3 << sh), 16'h0000, 2'h3, q);
         chk({15'h0, q[2]}, 16'h0001);
      end
      chk(16'(tx_cnt - c0), 16'h000A);
      chk({8'h00, obs}, 16'h00AA);
      $display("test decode done");
      // Emulation memory writes by lane, slave absent, shared strobe
      variant <= rsv_variant_two;
      lane_shift <= 2'h0;
      burst_shift <= 3'h0;
      for (int k = 0; k < 5; k++) begin
         slave_fitted <= ss[k][1];
         shared_write <= ss[k][0];
         @(posedge clk);
         acc(1'b1, 16'h0100, wd[k], wl[k], q);
         acc(1'b0, 16'h0100, 16'h0000, 2'h3, q);
         chk(q, ex[k]);
      end
      $display("test write done");
      // Master unit on the high lane moves the registers to D8-D15
      master_high_lane <= 1'b1;
      @(posedge clk);
      acc(1'b0, 16'hF802, 16'h0000, 2'h3, q);
      chk({8'h00, q[15:8]}, 16'h0077);
      $display("test lane done");
      final_report;
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (6000) @(posedge clk);
      num_errors++;
      final_report;
   end
endmodule // rom_socket_virtual_serial_port_tb
`default_nettype wire

// ==== tb/rsv_checker.sv ====
// Concurrent checks on the socket between the target and device ends
`timescale 1ns/1ps
`default_nettype none
module rsv_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Socket strobes and buses
   input wire logic rd_n,
   input wire logic mwr_n,
   input wire logic swr_n,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   // Interrupt pins
   input wire logic int_n_o,
   input wire logic int_n_oe,
   input wire logic int_p_o,
   input wire logic int_p_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////
   // Strobe low for eight cycles, then released high
   sequence rd_hold;
      !rd_n [*7] ##1 rd_n;
   endsequence
   sequence wr_hold;
      !mwr_n [*7] ##1 mwr_n;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   AST_INT_PAIR: assert property (int_n_oe == int_p_oe)
      else $error("interrupt enables disagree");
   AST_INT_N_LEVEL: assert property (int_n_oe |-> !int_n_o)
      else $error("low interrupt driven high");
   AST_INT_P_LEVEL: assert property (int_p_oe |-> int_p_o)
      else $error("high interrupt driven low");
   // Interrupt only drops while a read is under way
   AST_INT_CLEAR: assert property ($fell(int_p_oe) |-> !rd_n || !$past(rd_n))
      else $error("interrupt dropped without a read");
   AST_RD_LEN: assert property ($fell(rd_n) |=> rd_hold)
      else $error("read strobe length wrong");
   AST_WR_LEN: assert property ($fell(mwr_n) |=> wr_hold)
      else $error("write strobe length wrong");
   AST_RD_ADDR: assert property ($fell(rd_n) |=> $stable(addr) [*7])
      else $error("address moved during read");
   AST_WR_DATA: assert property ($fell(mwr_n) |=> $stable(wdata) [*7])
      else $error("write data moved during write");
   AST_ONE_ACCESS: assert property (!rd_n |-> mwr_n && swr_n)
      else $error("read and write overlap");
endmodule // rsv_checker
`default_nettype wire

// ==== verilog/rsv_cfg.svh ====
// Constants for the ROM socket virtual serial port
`ifndef RSV_CFG_SVH
`define RSV_CFG_SVH
`define RSV_ADDR_W 16
`define RSV_DATA_W 16
`define RSV_REG_ZERO 2'h0
`define RSV_REG_ONE 2'h1
`define RSV_REG_DATA 2'h2
`define RSV_REG_STAT 2'h3
`define RSV_STAT_PEND 0
`define RSV_STAT_TXIDLE 1
`define RSV_STAT_INIT 2
`define RSV_CHAR_BITS 4'h8
`define RSV_BASE_RST 16'hF800
`define RSV_MASK_RST 16'h07FF
`define RSV_LANE_SHIFT_MAX 2'h3
`define RSV_BURST_SHIFT_MAX 3'h5
`define RSV_BURST_SHIFT_V1 3'h4
`define RSV_REG_COUNT 16'h0004
`define RSV_STROBE_LAST 4'h7
`define RSV_PIN_IDLE 4'hF
`endif

// ==== verilog/rsv_device.sv ====
// ROM emulator end: register decode, memory, host character and interrupts
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module rsv_device
   import rsv_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Socket side
   rsv_if.device sock,
   // Configuration straps
   input wire rsv_variant_t variant,
   input wire logic [1:0] lane_shift,      // 0..3: 8/16/32/64-bit words
   input wire logic [2:0] burst_shift,     // 0..5: burst 1,2,4,8,16,32
   input wire logic master_high_lane,      // Master unit on D8-D15
   input wire logic slave_fitted,
   input wire logic shared_write,          // Older unit with one write pin
   input wire logic [15:0] reg_base,
   input wire logic [15:0] emu_mask,       // Emulation size minus one
   input wire logic [15:0] addr_mask,      // Variant one explicit mask
   input wire logic rx_int_en,
   input wire logic tx_int_en,
   // Host side
   input wire logic host_char_valid,       // One-cycle pulse with char
   input wire logic [7:0] host_char,
   input wire logic host_int_req,          // Handshake line from host
   output logic tx_bit_valid,
   output logic tx_bit
);
`include "rsv_cfg.svh"
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [3:0] pin_s1;                      // First stage only
   logic [3:0] pin_s2;                      // Second stage, used by logic
   logic [3:0] pin_d;                       // Previous of second stage
   // Strobes and request pass two flops before use; reset to idle levels
   // so that no false edge follows reset
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_s1 <= `RSV_PIN_IDLE;
         pin_s2 <= `RSV_PIN_IDLE;
         pin_d <= `RSV_PIN_IDLE;
      end else begin
         pin_s1 <= {~host_int_req, sock.rd_n, sock.mwr_n, sock.swr_n};
         pin_s2 <= pin_s1;
         pin_d <= pin_s2;
      end
   end
   wire rd_fall = pin_d[2] & ~pin_s2[2];
   wire mwr_fall = pin_d[1] & ~pin_s2[1];
   wire swr_fall = pin_d[0] & ~pin_s2[0];
   wire hreq_rise = pin_d[3] & ~pin_s2[3];
   // Address and data pass two flops like the strobes; they stand still
   // through the strobe, so decode sees the strobe's own address
   logic [15:0] addr_s1;                    // First stage only
   logic [15:0] wdata_s1;                   // First stage only
   logic [15:0] addr_q;
   logic [15:0] wdata_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         addr_s1 <= 16'h0000;
         wdata_s1 <= 16'h0000;
         addr_q <= 16'h0000;
         wdata_q <= 16'h0000;
      end else begin
         addr_s1 <= sock.addr;
         wdata_s1 <= sock.wdata;
         addr_q <= addr_s1;
         wdata_q <= wdata_s1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Register decode
   logic [2:0] bshift;
   logic [15:0] dec_mask;
   logic [15:0] rel;
   logic [3:0] sel_sh;
   logic hit;
   logic [1:0] reg_idx;
   always_comb begin
      // Variant one tops out at 16-byte bursts
      bshift = burst_shift;
      if (variant == rsv_variant_one && burst_shift > `RSV_BURST_SHIFT_V1) begin
         bshift = `RSV_BURST_SHIFT_V1;
      end else if (burst_shift > `RSV_BURST_SHIFT_MAX) begin
         bshift = `RSV_BURST_SHIFT_MAX;
      end
      // Variant two drops lines above the emulated size; one uses mask
      dec_mask = (variant == rsv_variant_two) ? emu_mask : addr_mask;
      rel = (addr_q - reg_base) & dec_mask;
      sel_sh = {2'b00, lane_shift} + {1'b0, bshift};
      // Window of four registers; bits below the stride are ignored
      hit = ((rel >> sel_sh) < `RSV_REG_COUNT);
      reg_idx = rel[sel_sh +: 2];
   end
   ////////////////////////////////////////////////////////////////////////
   // Emulation memory, one array per lane
   logic [7:0] mem_lo [0:2047];
   logic [7:0] mem_hi [0:2047];
   wire [10:0] mem_a = addr_q[11:1];
   wire lo_we = mwr_fall | (shared_write & swr_fall);
   wire hi_we = (slave_fitted & swr_fall) | (shared_write & mwr_fall);
   // Target writes land in memory, never in registers
   always_ff @(posedge clk) begin
      if (lo_we) begin
         mem_lo[mem_a] <= wdata_q[7:0];
      end
      if (hi_we) begin
         mem_hi[mem_a] <= wdata_q[15:8];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Channel state
   logic host_char_pending;
   logic [7:0] rx_char;
   logic channel_init_done;
   logic [3:0] tx_cnt;
   logic tx_idle_evt;
   logic int_req;
   // Host character capture; new arrival beats the clearing read
   always_ff @(posedge clk) begin
      if (srst) begin
         host_char_pending <= 1'b0;
         rx_char <= 8'h00;
      end else if (host_char_valid) begin
         host_char_pending <= 1'b1;
         rx_char <= host_char;
      end else if (rd_fall && hit && reg_idx == `RSV_REG_DATA) begin
         host_char_pending <= 1'b0;
      end
   end
   // Init done on first status read
   always_ff @(posedge clk) begin
      if (srst) begin
         channel_init_done <= 1'b0;
      end else if (rd_fall && hit && reg_idx == `RSV_REG_STAT) begin
         channel_init_done <= 1'b1;
      end
   end
   // Bit shifting toward host through reads alone
   always_ff @(posedge clk) begin
      if (srst) begin
         tx_bit_valid <= 1'b0;
         tx_bit <= 1'b0;
         tx_cnt <= 4'h0;
         tx_idle_evt <= 1'b0;
      end else begin
         tx_bit_valid <= 1'b0;
         tx_idle_evt <= 1'b0;
         if (rd_fall && hit && (reg_idx == `RSV_REG_ZERO || reg_idx == `RSV_REG_ONE)) begin
            tx_bit_valid <= 1'b1;
            tx_bit <= (reg_idx == `RSV_REG_ONE);
            if (tx_cnt == `RSV_CHAR_BITS - 4'h1) begin
               tx_cnt <= 4'h0;
               tx_idle_evt <= 1'b1;
            end else begin
               tx_cnt <= tx_cnt + 4'h1;
            end
         end
      end
   end
   // Interrupt request: pending char, idle transmitter (variant two only), or host request
   always_ff @(posedge clk) begin
      if (srst || !channel_init_done) begin
         int_req <= 1'b0;
      end else if (hreq_rise || (tx_idle_evt && tx_int_en && variant == rsv_variant_two)) begin
         int_req <= 1'b1;
      end else if (rd_fall && hit && reg_idx == `RSV_REG_DATA) begin
         int_req <= 1'b0;
      end
   end
   wire int_on = channel_init_done & ((host_char_pending & rx_int_en) | int_req);
   ////////////////////////////////////////////////////////////////////////
   // Socket outputs
   logic [7:0] reg_rd;
   always_comb begin
      reg_rd = 8'h00;
      unique case (reg_idx)
         `RSV_REG_DATA: reg_rd = rx_char;
         `RSV_REG_STAT: begin
            // Status fields at their named positions, other bits read zero
            reg_rd[`RSV_STAT_PEND] = host_char_pending;
            reg_rd[`RSV_STAT_TXIDLE] = (tx_cnt == 4'h0);
            reg_rd[`RSV_STAT_INIT] = channel_init_done;
         end
         default: reg_rd = 8'h00;
      endcase
   end
   // Read data: register on the master lane, memory elsewhere
   always_ff @(posedge clk) begin
      if (srst) begin
         sock.rdata <= 16'h0000;
         sock.int_n_o <= 1'b1;
         sock.int_n_oe <= 1'b0;
         sock.int_p_o <= 1'b0;
         sock.int_p_oe <= 1'b0;
      end else begin
         sock.rdata <= {mem_hi[mem_a], mem_lo[mem_a]};
         if (hit) begin
            if (master_high_lane) begin
               sock.rdata <= {reg_rd, mem_lo[mem_a]};
            end else begin
               sock.rdata <= {mem_hi[mem_a], reg_rd};
            end
         end
         // Drive only while asserted so the line can be shared
         sock.int_n_o <= 1'b0;
         sock.int_p_o <= 1'b1;
         sock.int_n_oe <= int_on;
         sock.int_p_oe <= int_on;
      end
   end
endmodule // rsv_device
`default_nettype wire

// ==== verilog/rsv_if.sv ====
// Interface joining the emulated ROM socket to the target processor
`timescale 1ns/1ps
`default_nettype none
interface rsv_if;
   logic rd_n;                // Target read strobe, active low
   logic mwr_n;               // Master lane write strobe, active low
   logic swr_n;               // Slave lane write strobe, active low
   logic [15:0] addr;         // Target address
   logic [15:0] wdata;        // Target write data
   logic [15:0] rdata;        // Socket read data
   logic int_n_o;             // Interrupt low asserted, driven value
   logic int_n_oe;            // Interrupt low asserted, enable
   logic int_p_o;             // Interrupt high asserted, driven value
   logic int_p_oe;            // Interrupt high asserted, enable
   // Shared lines resolve to pulled idle levels when nobody drives
   wire int_n_line = int_n_oe ? int_n_o : 1'b1;
   wire int_p_line = int_p_oe ? int_p_o : 1'b0;
   modport device (input rd_n, mwr_n, swr_n, addr, wdata, output rdata, int_n_o, int_n_oe, int_p_o, int_p_oe);
   modport target (output rd_n, mwr_n, swr_n, addr, wdata, input rdata, int_n_line, int_p_line);
endinterface
`default_nettype wire

// ==== verilog/rsv_pkg.sv ====
// Types shared by both ends of the ROM socket virtual serial port
`default_nettype none
package rsv_pkg;
   // Option variant of the device
   typedef enum logic {rsv_variant_one = 1'b0, rsv_variant_two = 1'b1} rsv_variant_t;
   // Target-side access engine states
   typedef enum logic [1:0] {rsv_idle = 2'b00, rsv_rd = 2'b01, rsv_wr = 2'b11} rsv_state_t;
endpackage
`default_nettype wire

// ==== verilog/rsv_target.sv ====
// Target processor end: issues socket reads and writes from a user port
`timescale 1ns/1ps
`default_nettype none
module rsv_target
   import rsv_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Socket side
   rsv_if.target sock,
   // User side
   input wire logic req_rd,                 // One-cycle start of read
   input wire logic req_wr,                 // One-cycle start of write
   input wire logic [15:0] req_addr,        // Uncached, already laid out
   input wire logic [15:0] req_wdata,
   input wire logic [1:0] req_lanes,        // Bit0 low lane, bit1 high
   output logic busy,
   output logic rd_valid,
   output logic [15:0] rd_data,
   output logic irq
);
`include "rsv_cfg.svh"
   rsv_state_t state;
   logic [3:0] hold;
   logic [1:0] irq_s;
   // Strobe held eight cycles so the device sampler sees it
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= rsv_idle;
         hold <= 4'h0;
         busy <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 16'h0000;
         sock.rd_n <= 1'b1;
         sock.mwr_n <= 1'b1;
         sock.swr_n <= 1'b1;
         sock.addr <= 16'h0000;
         sock.wdata <= 16'h0000;
      end else begin
         rd_valid <= 1'b0;
         unique case (state)
            rsv_idle: begin
               hold <= 4'h0;
               if (req_rd) begin
                  // Every access is a real read cycle, no caching
                  state <= rsv_rd;
                  busy <= 1'b1;
                  sock.addr <= req_addr;
                  sock.rd_n <= 1'b0;
               end else if (req_wr) begin
                  state <= rsv_wr;
                  busy <= 1'b1;
                  sock.addr <= req_addr;
                  sock.wdata <= req_wdata;
                  sock.mwr_n <= ~req_lanes[0];
                  sock.swr_n <= ~req_lanes[1];
               end
            end
            default: begin
               hold <= hold + 4'h1;
               if (hold == `RSV_STROBE_LAST) begin
                  if (state == rsv_rd) begin
                     rd_valid <= 1'b1;
                     rd_data <= sock.rdata;
                  end
                  state <= rsv_idle;
                  busy <= 1'b0;
                  sock.rd_n <= 1'b1;
                  sock.mwr_n <= 1'b1;
                  sock.swr_n <= 1'b1;
               end
            end
         endcase
      end
   end
   // Either interrupt pin raises the user interrupt
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_s <= 2'b00;
         irq <= 1'b0;
      end else begin
         irq_s <= {irq_s[0], ~sock.int_n_line | sock.int_p_line};
         irq <= irq_s[1];
      end
   end
endmodule // rsv_target
`default_nettype wire
